// file: maskable_irq_and_vector_select.sv
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "irq_vector_regs.svh"
module maskable_irq_and_vector_select
(
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     resetn,
  // apb slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  // sources, one bit per maskable source
  input  wire logic [`NUM_SRC-1:0]      irqEvent,
  // sequencer
  input  wire irq_vector_pkg::core_evt_t coreEvt,
  input  wire logic [14:0]              curPc,
  input  wire logic [14:0]              popAddr,
  output logic                          irqTake,
  output logic                          ackBusy,
  output logic                          pushReq,
  output logic      [14:0]              pushAddr,
  output irq_vector_pkg::pc_load_t      pcLoad,
  // vector fetch from program memory
  output logic                          memRdReq,
  output logic      [14:0]              memRdAddr,
  input  wire logic                     memRdValid,
  input  wire logic [7:0]               memRdData
);
  import irq_vector_pkg::*;

  // slot of each maskable source, lowest bit is port wakeup
  localparam logic [3:0] SRC_SLOT [`NUM_SRC] = '{4'h1, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd};

  seq_state_t         state_ff;
  logic [`NUM_SRC-1:0] enable_ff;
  logic [`NUM_SRC-1:0] pend_ff;
  logic               globalIrqEnable_ff;
  logic               trapPnd_ff;
  logic               trapSvc_ff;
  logic [4:0]         div_ff;
  logic [2:0]         ackCnt_ff;
  logic [6:0]         vecHi_ff;
  logic [`NUM_SRC-1:0] active;
  logic               trapBlock;
  logic               maskQual;
  logic               instrTick;
  logic               wrEn;
  logic               rdEn;
  logic [3:0]         winSlot;
  logic [6:0]         selBlock;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode, zero wait states
  assign pready  = 1'b1;
  assign wrEn    = psel && penable && pwrite;
  assign rdEn    = psel && penable && !pwrite;
  assign pslverr = psel && penable && !(paddr == `REG_IRQ_ENABLE || paddr == `REG_IRQ_PENDING
                                        || paddr == `REG_IRQ_CONTROL);

  always_comb
  begin
    prdata = 32'h0000_0000;
    if (rdEn && paddr == `REG_IRQ_ENABLE)
      prdata[`NUM_SRC-1:0] = enable_ff;
    else if (rdEn && paddr == `REG_IRQ_PENDING)
      prdata[`NUM_SRC-1:0] = pend_ff;
    else if (rdEn && paddr == `REG_IRQ_CONTROL)
    begin
      prdata[`CTL_GLOBAL_EN_BIT] = globalIrqEnable_ff;
      prdata[`CTL_TRAP_PND_BIT] = trapPnd_ff;
      prdata[`CTL_TRAP_SVC_BIT] = trapSvc_ff;
      prdata[`CTL_ACK_BUSY_BIT] = ackBusy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // enables and pending flags
  // enable bits
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      enable_ff <= `RST_ENABLE;
    else if (wrEn && paddr == `REG_IRQ_ENABLE)
      enable_ff <= pwdata[`NUM_SRC-1:0];
  end

  // set wins over a software write in the same cycle
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      pend_ff <= `RST_PENDING;
    else if (wrEn && paddr == `REG_IRQ_PENDING)
      pend_ff <= pwdata[`NUM_SRC-1:0] | irqEvent;
    else
      pend_ff <= pend_ff | irqEvent;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      globalIrqEnable_ff <= 1'b0;
    else if (irqTake)
      globalIrqEnable_ff <= 1'b0;
    else if (coreEvt.retExec)
      globalIrqEnable_ff <= 1'b1;
    else if (wrEn && paddr == `REG_IRQ_CONTROL)
      globalIrqEnable_ff <= pwdata[`CTL_GLOBAL_EN_BIT];
  end

  // trap pending, a new trap wins over the clear
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      trapPnd_ff <= 1'b0;
    else if (coreEvt.swTrapExec)
      trapPnd_ff <= 1'b1;
    else if (coreEvt.clrTrapExec)
      trapPnd_ff <= 1'b0;
  end

  // trap in service until its pending flag drops
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      trapSvc_ff <= 1'b0;
    else if (irqTake && trapPnd_ff)
      trapSvc_ff <= 1'b1;
    else if (!trapPnd_ff)
      trapSvc_ff <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // qualification and arbitration
  // active sources
  assign active    = enable_ff & pend_ff;
  assign trapBlock = trapPnd_ff || trapSvc_ff;
  // a level check, so a late enable or a return triggers at once
  assign maskQual  = (|active) && globalIrqEnable_ff && !trapBlock;
  // only at a normally executed instruction start
  assign irqTake   = (state_ff == ST_IDLE) && coreEvt.instrStart && !coreEvt.instrSkip
                     && (maskQual || (trapPnd_ff && !trapSvc_ff));
  assign ackBusy   = (state_ff == ST_ACK);

  // trap slot while a trap is pending, else highest ranked active source, else default slot
  always_comb
  begin
    winSlot = `SLOT_DEFAULT;
    for (int i = 0; i < `NUM_SRC; i++)
      if (active[i])
        winSlot = SRC_SLOT[i];
    if (trapPnd_ff)
      winSlot = `SLOT_TRAP;
  end

  // a select at the last byte of a block reads the next block
  assign selBlock = curPc[14:8] + {6'h00, curPc[7:0] == 8'hff};

  ////////////////////////////////////////////////////////////////////////////
  // instruction cycle divider, restarted on acknowledge for a fixed length
  assign instrTick = (div_ff == 5'(`INSTR_CLKS - 1));

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      div_ff <= 5'h00;
    else if (irqTake || instrTick)
      div_ff <= 5'h00;
    else
      div_ff <= div_ff + 5'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      state_ff <= ST_IDLE;
    else
      case (state_ff)
        ST_IDLE:
          if (irqTake)
            state_ff <= ST_ACK;
          else if (coreEvt.vecSelExec)
            state_ff <= ST_SEL_HI;
        ST_ACK:
          if (instrTick && ackCnt_ff == 3'(`ACK_INSTR_CYCLES - 1))
            state_ff <= ST_IDLE;
        ST_SEL_HI:
          if (memRdValid)
            state_ff <= ST_SEL_LO;
        ST_SEL_LO:
          if (memRdValid)
            state_ff <= ST_IDLE;
        default:
          state_ff <= ST_IDLE;
      endcase
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      ackCnt_ff <= 3'h0;
    else if (irqTake)
      ackCnt_ff <= 3'h0;
    else if (ackBusy && instrTick)
      ackCnt_ff <= ackCnt_ff + 3'h1;
  end

  // push the address of the instruction about to run
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      pushReq  <= 1'b0;
      pushAddr <= 15'h0000;
    end
    else
    begin
      pushReq <= irqTake;
      if (irqTake)
        pushAddr <= curPc;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      pcLoad <= '0;
    else if (ackBusy && instrTick && ackCnt_ff == 3'(`ACK_INSTR_CYCLES - 1))
      pcLoad <= '{valid: 1'b1, addr: `IRQ_ENTRY_ADDR};
    else if (state_ff == ST_IDLE && coreEvt.retExec)
      pcLoad <= '{valid: 1'b1, addr: popAddr};
    else if (state_ff == ST_SEL_LO && memRdValid)
      pcLoad <= '{valid: 1'b1, addr: {vecHi_ff, memRdData}};
    else
      pcLoad.valid <= 1'b0;
  end

  // even slot byte gives pc bits 14:8, odd slot byte the low pc byte, high byte first
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      memRdReq  <= 1'b0;
      memRdAddr <= 15'h0000;
      vecHi_ff  <= 7'h00;
    end
    else if (state_ff == ST_IDLE && !irqTake && coreEvt.vecSelExec)
    begin
      memRdReq  <= 1'b1;
      memRdAddr <= {selBlock, `VEC_TABLE_BASE | {3'b000, winSlot, 1'b0}};
    end
    else if (state_ff == ST_SEL_HI && memRdValid)
    begin
      vecHi_ff  <= memRdData[6:0];
      memRdAddr <= memRdAddr | 15'h0001;
    end
    else if (state_ff == ST_SEL_LO && memRdValid)
      memRdReq <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_pend_set_event:
    assert property (@(posedge clk_sys) disable iff (!resetn)
      (irqEvent != 6'h00) |=> ((pend_ff & $past(irqEvent)) == $past(irqEvent)))
    else $error("event did not set pending");
  chk_take_qualified:
    assert property (@(posedge clk_sys) disable iff (!resetn)
      irqTake && !trapPnd_ff |-> globalIrqEnable_ff && (|(enable_ff & pend_ff)) && !trapSvc_ff)
    else $error("maskable take without qualification");
  chk_skip_no_take:
    assert property (@(posedge clk_sys) disable iff (!resetn)
      coreEvt.instrSkip |-> !irqTake)
    else $error("take on skipped instruction");
  chk_ack_clears_push:
    assert property (@(posedge clk_sys) disable iff (!resetn)
      irqTake |=> !globalIrqEnable_ff && pushReq && pushAddr == $past(curPc))
    else $error("ack did not clear enable or push");
  chk_ack_seven_cycles:
    assert property (@(posedge clk_sys) disable iff (!resetn)
      irqTake |-> ##141 (pcLoad.valid && pcLoad.addr == 15'h00ff))
    else $error("entry load not after seven instruction cycles");
  chk_ret_restores:
    assert property (@(posedge clk_sys) disable iff (!resetn)
      coreEvt.retExec && state_ff == ST_IDLE && !irqTake |=> globalIrqEnable_ff && pcLoad.valid
      && pcLoad.addr == $past(popAddr))
    else $error("return did not restore");
  chk_sel_even_slot:
    assert property (@(posedge clk_sys) disable iff (!resetn)
      $rose(memRdReq) |-> memRdAddr[0] == 1'b0 && memRdAddr[7:5] == 3'b111)
    else $error("vector address not an even table byte");
  chk_sel_default:
    assert property (@(posedge clk_sys) disable iff (!resetn)
      state_ff == ST_IDLE && coreEvt.vecSelExec && !irqTake && active == 6'h00 && !trapPnd_ff
      |=> memRdAddr[7:0] == 8'he0)
    else $error("default entry not used");
  chk_trap_masks:
    assert property (@(posedge clk_sys) disable iff (!resetn)
      trapSvc_ff |-> !irqTake)
    else $error("take while trap in service");
  chk_pend_stays:
    assert property (@(posedge clk_sys) disable iff (!resetn)
      !(wrEn && paddr == `REG_IRQ_PENDING) |=> (pend_ff & $past(pend_ff)) == $past(pend_ff))
    else $error("pending flag lost without a write");
  chk_level_take:
    assert property (@(posedge clk_sys) disable iff (!resetn)
      state_ff == ST_IDLE && coreEvt.instrStart && !coreEvt.instrSkip && (|(enable_ff & pend_ff))
      && globalIrqEnable_ff && !trapPnd_ff && !trapSvc_ff |-> irqTake)
    else $error("qualified source not taken");
  chk_ack_busy_span:
    assert property (@(posedge clk_sys) disable iff (!resetn)
      irqTake |=> ackBusy ##139 ackBusy ##1 !ackBusy)
    else $error("acknowledge span not seven instruction cycles");
  chk_nest_enable:
    assert property (@(posedge clk_sys) disable iff (!resetn)
      wrEn && paddr == `REG_IRQ_CONTROL && pwdata[`CTL_GLOBAL_EN_BIT] && !irqTake |=> globalIrqEnable_ff)
    else $error("global enable write not taken");
  chk_sel_block:
    assert property (@(posedge clk_sys) disable iff (!resetn)
      $rose(memRdReq) |-> memRdAddr[14:8] == 7'($past(curPc[14:8]) + 7'($past(curPc[7:0]) == 8'hff)))
    else $error("vector table in the wrong block");
  chk_vec_hi_first:
    assert property (@(posedge clk_sys) disable iff (!resetn)
      state_ff == ST_SEL_HI && memRdValid |=> memRdAddr[0] && vecHi_ff == $past(memRdData[6:0]))
    else $error("high vector byte not taken first");
  chk_trap_slot:
    assert property (@(posedge clk_sys) disable iff (!resetn)
      state_ff == ST_IDLE && coreEvt.vecSelExec && !irqTake && trapPnd_ff
      |=> memRdAddr[7:0] == 8'hfe)
    else $error("trap vector not at top of table");
  chk_sel_highest:
    assert property (@(posedge clk_sys) disable iff (!resetn)
      state_ff == ST_IDLE && coreEvt.vecSelExec && !irqTake && !trapPnd_ff && active[5]
      |=> memRdAddr[7:0] == 8'hfa)
    else $error("highest ranked source not selected");
  chk_trap_clear:
    assert property (@(posedge clk_sys) disable iff (!resetn)
      coreEvt.clrTrapExec && !coreEvt.swTrapExec |=> !trapPnd_ff)
    else $error("clear instruction left trap pending");

endmodule // maskable_irq_and_vector_select

// file: irq_vector_regs.svh
`ifndef IRQ_VECTOR_REGS_SVH
`define IRQ_VECTOR_REGS_SVH
// apb register byte offsets
`define REG_IRQ_ENABLE   12'h000
`define REG_IRQ_PENDING  12'h004
`define REG_IRQ_CONTROL  12'h008
// control register fields
`define CTL_GLOBAL_EN_BIT 0
`define CTL_TRAP_PND_BIT 1
`define CTL_TRAP_SVC_BIT 2
`define CTL_ACK_BUSY_BIT 3
// reset values
`define RST_ENABLE       6'h00
`define RST_PENDING      6'h00
// maskable sources
`define NUM_SRC          6
// table slots, E0 plus two per slot
`define SLOT_TRAP        4'hf
`define SLOT_DEFAULT     4'h0
`define VEC_TABLE_BASE   8'he0
`define IRQ_ENTRY_ADDR   15'h00ff
// timing
`define CLK_NS           50
`define INSTR_NS         1000
`define INSTR_CLKS       ((`INSTR_NS + `CLK_NS - 1) / `CLK_NS)
`define ACK_INSTR_CYCLES 7
`endif

// file: irq_vector_pkg.sv
package irq_vector_pkg;
  typedef enum logic [2:0]
  {
    ST_IDLE   = 3'b000,
    ST_ACK    = 3'b001,
    ST_SEL_HI = 3'b011,
    ST_SEL_LO = 3'b010
  } seq_state_t;
  // instruction boundary events from the sequencer
  typedef struct packed {
    logic instrStart;
    logic instrSkip;
    logic retExec;
    logic vecSelExec;
    logic clrTrapExec;
    logic swTrapExec;
  } core_evt_t;
  typedef struct packed {
    logic        valid;
    logic [14:0] addr;
  } pc_load_t;
endpackage

// file: vec_mem_model.sv
`timescale 1ns/1ps
module vec_mem_model
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // vector fetch
  input  wire logic        memRdReq,
  input  wire logic [14:0] memRdAddr,
  output logic             memRdValid,
  output logic [7:0]       memRdData
);
  logic slow;
  initial
  begin
    memRdValid = 1'b0;
    memRdData  = 8'h00;
    slow       = 1'b0;
    forever
    begin
      @(posedge clk_sys);
      if (resetn && memRdReq)
      begin
        // answer fast and slow in turn
        repeat (slow ? 3 : 1) @(posedge clk_sys);
        // table preloaded: high byte is the page, low byte the offset
        memRdValid <= 1'b1;
        memRdData  <= memRdAddr[0] ? memRdAddr[7:0] : {1'b0, memRdAddr[14:8]};
        @(posedge clk_sys);
        memRdValid <= 1'b0;
        // released data must not look valid
        memRdData  <= ~memRdData;
        slow = ~slow;
        // request drops a cycle late, so skip it
        if (memRdAddr[0])
          repeat (2) @(posedge clk_sys);
      end
    end
  end
endmodule // vec_mem_model

// file: maskable_irq_and_vector_select_bench.sv
`timescale 1ns/1ps
`include "irq_vector_regs.svh"
module maskable_irq_and_vector_select_bench;
  import irq_vector_pkg::*;
  typedef struct {logic [5:0] en, ev; logic [14:0] pc; logic [3:0] s;} row_t;
  localparam core_evt_t EV_GO = 6'b100000, EV_SKIP = 6'b110000, EV_RET = 6'b001000;
  localparam core_evt_t EV_SEL = 6'b000100, EV_CLR = 6'b000010, EV_TRAP = 6'b000001;
  logic        clk_sys = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        pready, pslverr, er, irqTake, ackBusy, pushReq, memRdReq, memRdValid;
  logic [5:0]  irqEvent = 0;
  logic [14:0] curPc = 0, popAddr = 0, pushAddr, memRdAddr;
  logic [7:0]  memRdData;
  core_evt_t   coreEvt = '0;
  pc_load_t    pcLoad;
  int          miscompares = 0, n_compared = 0, c;
  row_t        rows[10] = '{
    '{6'h3f, 6'h01, 15'h00ff, 4'h1}, '{6'h3f, 6'h02, 15'h01df, 4'h9},
    '{6'h3f, 6'h04, 15'h0123, 4'ha}, '{6'h3f, 6'h08, 15'h02ff, 4'hb},
    '{6'h3f, 6'h10, 15'h0200, 4'hc}, '{6'h3f, 6'h20, 15'h7f00, 4'hd},
    '{6'h3f, 6'h3f, 15'h0100, 4'hd}, '{6'h1f, 6'h3f, 15'h03fe, 4'hc},
    '{6'h00, 6'h3f, 15'h04ff, 4'h0}, '{6'h3e, 6'h07, 15'h0500, 4'ha}};

  always #25 clk_sys = ~clk_sys;

  maskable_irq_and_vector_select dut (.clk_sys, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .irqEvent, .coreEvt, .curPc, .popAddr, .irqTake, .ackBusy, .pushReq,
    .pushAddr, .pcLoad, .memRdReq, .memRdAddr, .memRdValid, .memRdData);
  vec_mem_model mem (.clk_sys, .resetn, .memRdReq, .memRdAddr, .memRdValid, .memRdData);

  ////////////////////////////////////////////////////////////
  task results();
    if (miscompares == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task check(string nm, logic [31:0] got, logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // called at a rising edge; waits on pready with no fixed count
  task apb(logic w, logic [11:0] a, logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  // one-cycle sequencer event; an edge passes first so no double drive
  task pulse(core_evt_t e, logic take);
    @(posedge clk_sys);
    coreEvt <= e;
    #1 check("take", irqTake, take);
    @(posedge clk_sys);
    coreEvt <= '0;
  endtask

  task waitld(logic [14:0] a, int cyc);
    c = 0;
    #1;
    while (pcLoad.valid !== 1'b1 && c < 300)
    begin
      @(posedge clk_sys);
      #1 c++;
    end
    check("loaded", pcLoad.valid, 1);
    check("load", pcLoad.addr, a);
    if (cyc >= 0)
      check("cycles", c, cyc);
    @(posedge clk_sys);
  endtask

  task sel(logic [14:0] pc, logic [3:0] s);
    logic [7:0] v;
    logic [6:0] b;
    v = 8'he0 + 8'({s, 1'b0});
    b = pc[14:8] + 7'(pc[7:0] == 8'hff);
    curPc <= pc;
    pulse(EV_SEL, 1'b0);
    waitld({b, v | 8'h01}, -1);
  endtask

  task ack();
    pulse(EV_GO, 1'b1);
    #1 check("push", pushReq, 1);
    check("pushAddr", pushAddr, curPc);
    check("busy", ackBusy, 1);
    waitld(15'h00ff, `ACK_INSTR_CYCLES * `INSTR_CLKS);
  endtask

  ////////////////////////////////////////////////////////////
  initial
  begin
    #(50 * 4000);
    miscompares++;
    results();
  end

  initial
  begin
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b0, 12'(4 * i), 0);
      check("reset", rd, 0);
    end
    apb(1'b0, 12'h00c, 0);
    check("slverr", er, 1);
    check("unmapped", rd, 0);
    check("ready", pready, 1);
    apb(1'b1, 12'h000, 32'h0000_003f);
    apb(1'b0, 12'h000, 0);
    check("enable", rd, 32'h0000_003f);
    foreach (rows[i])
    begin
      apb(1'b1, 12'h004, 0);
      apb(1'b1, 12'h000, 32'(rows[i].en));
      irqEvent <= rows[i].ev;
      @(posedge clk_sys);
      irqEvent <= '0;
      sel(rows[i].pc, rows[i].s);
      apb(1'b0, 12'h004, 0);
      check("pending", rd, 32'(rows[i].ev));
    end
    pulse(EV_GO, 1'b0);
    apb(1'b1, 12'h008, 1);
    pulse(EV_SKIP, 1'b0);
    curPc <= 15'h1234;
    ack();
    apb(1'b0, 12'h008, 0);
    check("ctl", rd, 0);
    popAddr <= 15'h0456;
    @(posedge clk_sys);
    coreEvt <= EV_RET;
    #1 check("take", irqTake, 0);
    @(posedge clk_sys);
    coreEvt <= '0;
    #1 check("retload", pcLoad.valid, 1);
    check("load", pcLoad.addr, 15'h0456);
    @(posedge clk_sys);
    #1 check("retpulse", pcLoad.valid, 0);
    @(posedge clk_sys);
    apb(1'b0, 12'h008, 0);
    check("ctl", rd, 1);
    ack();
    apb(1'b1, 12'h004, 0);
    pulse(EV_TRAP, 1'b0);
    ack();
    apb(1'b0, 12'h008, 0);
    check("ctl", rd, 32'h0000_0006);
    apb(1'b1, 12'h004, 32'h0000_0020);
    apb(1'b1, 12'h008, 1);
    sel(15'h0150, 4'hf);
    pulse(EV_GO, 1'b0);
    pulse(EV_CLR, 1'b0);
    apb(1'b0, 12'h008, 0);
    check("ctl", rd, 1);
    ack();
    // mid-run reset with enables, a pending flag and the global enable all set
    apb(1'b1, 12'h008, 1);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b0, 12'(4 * i), 0);
      check("rerun", rd, 0);
    end
    results();
  end
endmodule // maskable_irq_and_vector_select_bench
